// [hdl/spe_ctl.sv]
// partner master: frames bytes, drives clock and select, reads back data
`timescale 1ns/1ns
module spe_ctl
	import spe_pkg::*;
(
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	// register port
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// serial link
	spe_link_if.ctl link
);
	logic [3:0] cfg_r; // phase, polarity, hold, enable
	logic [7:0] rx_r; // last received byte
	logic done_r; // sticky byte complete
	logic [7:0] sh_r; // output shifter
	logic [7:0] in_r; // input shifter
	logic [3:0] tg_r; // clock toggles
	logic [6:0] dcnt_r; // half period counter
	logic sck_r, ss_r; // link levels
	logic miso_q1, miso_q2; // synchroniser
	logic [7:0] rdata_r; // read data
	spe_st_t st_r; // framing state

	// decoded controls and edges
	logic clock_phase_bit, cpol, tick, lead, samp, shft, go;
	assign clock_phase_bit = cfg_r[SPE_CB_CLOCK_PHASE_BIT];
	assign cpol = cfg_r[SPE_CB_CPOL];
	assign tick = dcnt_r == SPE_HALF_CYC - 7'h1;
	assign lead = st_r == SPE_SHIFT && tick && sck_r == cpol;
	assign samp = st_r == SPE_SHIFT && tick && (clock_phase_bit ? sck_r != cpol :
		sck_r == cpol);
	assign shft = st_r == SPE_SHIFT && tick && (clock_phase_bit ? (lead && tg_r !=
		4'h0) : sck_r != cpol);
	assign go = wr && addr == SPE_C_TX && cfg_r[SPE_CB_EN] &&
		st_r == SPE_IDLE;

	// miso synchroniser
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			{miso_q1, miso_q2} <= 2'h3;
		end else if (ce) begin
			miso_q1 <= link.miso;
			miso_q2 <= miso_q1;
		end
	end

	// configuration register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_r <= SPE_CFG_RST;
		end else if (ce && wr && addr == SPE_C_CFG) begin
			cfg_r <= wdata[3:0];
		end
	end

	// sticky done, cleared by status read, set wins
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			done_r <= 1'b0;
		end else if (ce) begin
			if (st_r == SPE_SHIFT && tick && tg_r == SPE_LAST_TGL) begin
				done_r <= 1'b1;
			end else if (rd && addr == SPE_C_STAT) begin
				done_r <= 1'b0;
			end
		end
	end

	// framing machine
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= SPE_IDLE;
			sh_r <= 8'h00;
			in_r <= 8'h00;
			rx_r <= 8'h00;
			tg_r <= 4'h0;
			dcnt_r <= 7'h00;
			sck_r <= 1'b0;
			ss_r <= 1'b1;
		end else if (ce) begin
			dcnt_r <= (tick || st_r == SPE_IDLE) ? 7'h00 : dcnt_r + 7'h1;
			if (!cfg_r[SPE_CB_EN]) begin
				// disabled mid-frame: drop the frame, lines back to idle
				st_r <= SPE_IDLE;
				sck_r <= cpol;
				ss_r <= 1'b1;
			end else begin
			unique case (st_r)
				SPE_IDLE: begin
					sck_r <= cpol;
					if (!cfg_r[SPE_CB_EN]) begin
						ss_r <= 1'b1;
					end
					if (go) begin
						sh_r <= wdata;
						ss_r <= 1'b0; // start edge
						st_r <= SPE_SETUP;
					end
				end
				SPE_SETUP: begin
					// select low ahead of first edge
					if (tick) begin
						tg_r <= 4'h0;
						st_r <= SPE_SHIFT;
					end
				end
				SPE_SHIFT: begin
					if (tick) begin
						sck_r <= ~sck_r;
						tg_r <= tg_r + 4'h1;
						if (tg_r == SPE_LAST_TGL) begin
							st_r <= SPE_GAP;
							rx_r <= samp ? {in_r[6:0], miso_q2} : in_r;
						end
					end
					if (samp) begin
						in_r <= {in_r[6:0], miso_q2};
					end
					if (shft) begin
						sh_r <= {sh_r[6:0], 1'b0};
					end
				end
				SPE_GAP: begin
					// select held past the last edge so the slave sees
					// its last edge before the rise, then high a half period unless hold is set with phase 1
					if (tick) begin
						if (tg_r == 4'h0) begin
							tg_r <= 4'h1;
							ss_r <= !(clock_phase_bit && cfg_r[SPE_CB_HOLD]);
						end else begin
							st_r <= SPE_IDLE;
						end
					end
				end
			endcase
			end
		end
	end

	// registered read data
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= 8'h00;
		end else if (ce) begin
			if (!rd) begin
				rdata_r <= 8'h00;
			end else begin
				unique case (addr)
					SPE_C_CFG: rdata_r <= {4'h0, cfg_r};
					SPE_C_TX: rdata_r <= 8'h00;
					SPE_C_RX: rdata_r <= rx_r;
					SPE_C_STAT: rdata_r <= {6'h00, done_r,
						st_r != SPE_IDLE};
				endcase
			end
		end
	end

	// outputs
	assign rdata = rdata_r;
	assign link.ctl_sck = sck_r;
	assign link.ctl_mosi = sh_r[7];
	assign link.ctl_ss_b = ss_r;
	assign link.ctl_oe = cfg_r[SPE_CB_EN];
endmodule : spe_ctl

// [hdl/spe_dev.sv]
// serial peripheral port: framing, select handling, error flags, requests
`timescale 1ns/1ns
module spe_dev
	import spe_pkg::*;
(
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	// register port
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// interrupt requests
	output logic irq_tx,
	output logic irq_err,
	// serial link
	spe_link_if.dev link
);
	logic [7:0] ctrl_r; // control register
	logic transfer_done_flag_r, write_clash_flag_r, early_deselect_flag_r, role_conflict_flag_r; // status flags
	logic arm_r; // status accessed, data access pending
	logic role_conflict_flag_arm_r; // status read while fault set
	logic [7:0] tx_r; // byte to send
	logic [7:0] rx_r; // received byte buffer
	logic [7:0] sh_r; // output shifter
	logic [7:0] in_r; // input shifter
	logic [2:0] cnt_r; // samples taken
	logic [3:0] tg_r; // master clock toggles
	logic [6:0] dcnt_r; // master divider
	logic msck_r; // master clock level
	logic [7:0] rdata_r; // read data
	spe_st_t st_r; // transfer state
	// synchroniser stages
	logic sck_q1, sck_q2, sck_q3;
	logic ss_q1, ss_q2, ss_q3;
	logic mosi_q1, mosi_q2, miso_q1, miso_q2;

	// decoded controls
	logic en, controller_role_bit, cpol, clock_phase_bit, select_pin_disable, select_pin_disable_eff, sel, busy;
	assign en = ctrl_r[SPE_B_EN];
	assign controller_role_bit = ctrl_r[SPE_B_CONTROLLER_ROLE_BIT];
	assign cpol = ctrl_r[SPE_B_CPOL];
	assign clock_phase_bit = ctrl_r[SPE_B_CLOCK_PHASE_BIT];
	assign select_pin_disable = ctrl_r[SPE_B_SELECT_PIN_DISABLE];
	assign select_pin_disable_eff = select_pin_disable & clock_phase_bit; // no effect with phase 0
	assign sel = ~ss_q2 | select_pin_disable_eff;
	assign busy = (st_r == SPE_SHIFT);

	// register access strobes
	logic wr_ctrl, rd_stat, acc_stat, acc_data, wr_data;
	assign wr_ctrl = wr && addr == SPE_A_CTRL;
	assign rd_stat = rd && addr == SPE_A_STAT;
	assign acc_stat = (rd || wr) && addr == SPE_A_STAT;
	assign acc_data = (rd || wr) && addr == SPE_A_DATA;
	assign wr_data = wr && addr == SPE_A_DATA;

	// link edge detection
	logic s_lead, s_trail, ss_fall, ss_rise, tick, m_lead, m_trail;
	assign s_lead = (sck_q2 != cpol) && (sck_q3 == cpol);
	assign s_trail = (sck_q2 == cpol) && (sck_q3 != cpol);
	assign ss_fall = ~ss_q2 & ss_q3;
	assign ss_rise = ss_q2 & ~ss_q3;
	assign tick = busy && controller_role_bit && dcnt_r == spe_half(
		{ctrl_r[7], ctrl_r[1:0]}) - 7'h1;
	assign m_lead = tick && msck_r == cpol;
	assign m_trail = tick && msck_r != cpol;

	// sample and shift edges by phase
	logic lead, trail, samp, shft, start, done, abort;
	assign lead = controller_role_bit ? m_lead : (s_lead && sel);
	assign trail = controller_role_bit ? m_trail : (s_trail && sel);
	assign samp = clock_phase_bit ? trail : lead;
	// master phase 1: first leading edge only starts driving
	assign shft = (clock_phase_bit ? lead : trail) &&
		!(controller_role_bit && clock_phase_bit && tg_r == 4'h0);
	assign start = en && !busy && (controller_role_bit ? wr_data :
		(clock_phase_bit ? (s_lead && sel) : ss_fall));
	assign done = busy && (controller_role_bit ? (tick && tg_r == SPE_LAST_TGL) :
		(samp && cnt_r == SPE_LAST_BIT));
	assign abort = busy && !controller_role_bit && ss_rise && !select_pin_disable_eff;

	// fault detect and clear
	logic role_conflict_flag_set, role_conflict_flag_clr, flag_clr;
	assign role_conflict_flag_set = en && controller_role_bit && !select_pin_disable && !ss_q2;
	assign role_conflict_flag_clr = wr_ctrl && role_conflict_flag_arm_r;
	assign flag_clr = acc_data && arm_r;

	// two-stage synchronisers plus edge history
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			{sck_q1, sck_q2, sck_q3} <= 3'h0;
			{ss_q1, ss_q2, ss_q3} <= 3'h7;
			{mosi_q1, mosi_q2, miso_q1, miso_q2} <= 4'hf;
		end else if (ce) begin
			sck_q1 <= link.sck;
			sck_q2 <= sck_q1;
			sck_q3 <= sck_q2;
			ss_q1 <= link.ss_b;
			ss_q2 <= ss_q1;
			ss_q3 <= ss_q2;
			mosi_q1 <= link.mosi;
			mosi_q2 <= mosi_q1;
			miso_q1 <= link.miso;
			miso_q2 <= miso_q1;
		end
	end

	// control register, fault drops enable and role
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= SPE_CTRL_RST;
		end else if (ce) begin
			if (role_conflict_flag_set) begin
				ctrl_r <= (wr_ctrl ? wdata : ctrl_r) &
					~(8'h1 << SPE_B_EN) & ~(8'h1 << SPE_B_CONTROLLER_ROLE_BIT);
			end else if (wr_ctrl) begin
				ctrl_r <= wdata; // left to software
			end
		end
	end

	// fault flag and its clearing sequence
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			role_conflict_flag_r <= 1'b0;
			role_conflict_flag_arm_r <= 1'b0;
		end else if (ce) begin
			if (role_conflict_flag_set) begin
				role_conflict_flag_r <= 1'b1; // set wins over clear
			end else if (role_conflict_flag_clr) begin
				role_conflict_flag_r <= 1'b0;
			end
			if (rd_stat) begin
				role_conflict_flag_arm_r <= role_conflict_flag_r;
			end else if (wr_ctrl) begin
				role_conflict_flag_arm_r <= 1'b0;
			end
		end
	end

	// done and clash flags, cleared by status then data access
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			transfer_done_flag_r <= 1'b0;
			write_clash_flag_r <= 1'b0;
			arm_r <= 1'b0;
		end else if (ce) begin
			if (done) begin
				transfer_done_flag_r <= 1'b1;
			end else if (flag_clr) begin
				transfer_done_flag_r <= 1'b0;
			end
			if (wr_data && busy) begin
				write_clash_flag_r <= 1'b1;
			end else if (flag_clr) begin
				write_clash_flag_r <= 1'b0;
			end
			if (acc_stat) begin
				arm_r <= 1'b1;
			end else if (acc_data) begin
				arm_r <= 1'b0;
			end
		end
	end

	// deselect error, cleared only by disabling the port
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			early_deselect_flag_r <= 1'b0;
		end else if (ce) begin
			if (!en) begin
				early_deselect_flag_r <= 1'b0;
			end else if (abort) begin
				early_deselect_flag_r <= 1'b1;
			end
		end
	end

	// transmit byte, refused while a transfer runs
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tx_r <= 8'h00;
		end else if (ce && wr_data && !busy) begin
			tx_r <= wdata;
		end
	end

	// receive buffer keeps first byte since last clear
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rx_r <= 8'h00;
		end else if (ce && done && (!transfer_done_flag_r || flag_clr)) begin
			rx_r <= {in_r[6:0], samp ? (controller_role_bit ? miso_q2 : mosi_q2) :
				in_r[0]};
		end
	end

	// transfer machine, held idle while disabled
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= SPE_IDLE;
			sh_r <= 8'h00;
			in_r <= 8'h00;
			cnt_r <= 3'h0;
			tg_r <= 4'h0;
			dcnt_r <= 7'h00;
			msck_r <= 1'b0;
		end else if (ce) begin
			if (!en) begin
				st_r <= SPE_IDLE;
				msck_r <= cpol;
			end else if (start) begin
				st_r <= SPE_SHIFT;
				// loaded MSB drives before first sample edge
				sh_r <= wr_data ? wdata : tx_r;
				cnt_r <= 3'h0;
				tg_r <= 4'h0;
				dcnt_r <= 7'h00;
				msck_r <= cpol;
			end else if (done || abort) begin
				st_r <= SPE_IDLE; // transfer ran to its end or was aborted by early deselect
				msck_r <= cpol;
			end else if (busy) begin
				// master divider and clock toggles
				if (tick) begin
					dcnt_r <= 7'h00;
					msck_r <= ~msck_r;
					tg_r <= tg_r + 4'h1;
				end else if (controller_role_bit) begin
					dcnt_r <= dcnt_r + 7'h1;
				end
				if (samp) begin
					in_r <= {in_r[6:0], controller_role_bit ? miso_q2 : mosi_q2};
					cnt_r <= cnt_r + 3'h1;
				end
				if (shft) begin
					sh_r <= {sh_r[6:0], 1'b0};
				end
			end else begin
				msck_r <= cpol;
			end
		end
	end

	// registered read data, unmapped reads zero
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= 8'h00;
		end else if (ce) begin
			if (!rd) begin
				rdata_r <= 8'h00;
			end else begin
				unique case (addr)
					SPE_A_CTRL: rdata_r <= ctrl_r;
					SPE_A_STAT: rdata_r <= {transfer_done_flag_r, write_clash_flag_r, early_deselect_flag_r, role_conflict_flag_r,
						4'h0};
					SPE_A_DATA: rdata_r <= rx_r;
					default: rdata_r <= 8'h00;
				endcase
			end
		end
	end

	// outputs
	assign rdata = rdata_r;
	assign irq_tx = transfer_done_flag_r;
	assign irq_err = role_conflict_flag_r && !select_pin_disable;
	assign link.dev_sck = msck_r;
	assign link.dev_sck_oe = en && controller_role_bit;
	assign link.dev_mosi = sh_r[7];
	assign link.dev_mosi_oe = en && controller_role_bit;
	assign link.dev_miso = sh_r[7];
	assign link.dev_miso_oe = en && !controller_role_bit && sel;
endmodule : spe_dev

// [include/spe_link_if.sv]
// serial link between the port and its partner, with wire resolution
`timescale 1ns/1ns
interface spe_link_if;
	// port end drives
	logic dev_sck;
	logic dev_sck_oe;
	logic dev_mosi;
	logic dev_mosi_oe;
	logic dev_miso;
	logic dev_miso_oe;
	// partner end drives
	logic ctl_sck;
	logic ctl_mosi;
	logic ctl_ss_b;
	logic ctl_oe;
	// resolved wires, idle levels from pulls
	logic sck;
	logic mosi;
	logic miso;
	logic ss_b;
	assign sck = dev_sck_oe ? dev_sck : (ctl_oe ? ctl_sck : 1'b0);
	assign mosi = dev_mosi_oe ? dev_mosi : (ctl_oe ? ctl_mosi : 1'b1);
	assign miso = dev_miso_oe ? dev_miso : 1'b1;
	assign ss_b = ctl_oe ? ctl_ss_b : 1'b1;
	// documented port
	modport dev (input sck, mosi, miso, ss_b,
		output dev_sck, dev_sck_oe, dev_mosi, dev_mosi_oe,
		dev_miso, dev_miso_oe);
	// partner master
	modport ctl (input miso, output ctl_sck, ctl_mosi, ctl_ss_b, ctl_oe);
endinterface : spe_link_if

// [include/spe_pkg.sv]
// shared constants, types and helpers for the serial port and its partner
package spe_pkg;
	// device register indices
	localparam logic [1:0] SPE_A_CTRL = 2'h0;
	localparam logic [1:0] SPE_A_STAT = 2'h1;
	localparam logic [1:0] SPE_A_DATA = 2'h2;
	// control register value after reset
	localparam logic [7:0] SPE_CTRL_RST = 8'h14;
	// control field positions
	localparam int SPE_B_EN = 6;
	localparam int SPE_B_SELECT_PIN_DISABLE = 5;
	localparam int SPE_B_CONTROLLER_ROLE_BIT = 4;
	localparam int SPE_B_CPOL = 3;
	localparam int SPE_B_CLOCK_PHASE_BIT = 2;
	// status field positions
	localparam int SPE_B_TRANSFER_DONE_FLAG = 7;
	localparam int SPE_B_WRITE_CLASH_FLAG = 6;
	localparam int SPE_B_EARLY_DESELECT_FLAG = 5;
	localparam int SPE_B_ROLE_CONFLICT_FLAG = 4;
	// one byte: last sample index, last toggle index
	localparam logic [2:0] SPE_LAST_BIT = 3'h7;
	localparam logic [3:0] SPE_LAST_TGL = 4'hf;
	// controller register indices
	localparam logic [1:0] SPE_C_CFG = 2'h0;
	localparam logic [1:0] SPE_C_TX = 2'h1;
	localparam logic [1:0] SPE_C_RX = 2'h2;
	localparam logic [1:0] SPE_C_STAT = 2'h3;
	// controller config positions: phase, polarity, hold select, enable
	localparam int SPE_CB_CLOCK_PHASE_BIT = 0;
	localparam int SPE_CB_CPOL = 1;
	localparam int SPE_CB_HOLD = 2;
	localparam int SPE_CB_EN = 3;
	localparam logic [3:0] SPE_CFG_RST = 4'h0;
	// controller link clock timing
	localparam int SPE_MCLK_NS = 4;
	localparam int SPE_LINK_NS = 80;
	localparam logic [6:0] SPE_HALF_CYC =
		7'(SPE_LINK_NS / (2 * SPE_MCLK_NS));
	// transfer states
	typedef enum logic [1:0] {SPE_IDLE, SPE_SETUP, SPE_SHIFT, SPE_GAP}
		spe_st_t;
	// half serial clock period in mclk cycles from the rate field
	function automatic logic [6:0] spe_half(input logic [2:0] rate);
		logic [2:0] r;
		r = (rate == 3'h0 || rate == 3'h7) ? 3'h1 : rate;
		return 7'(7'h1 << r);
	endfunction : spe_half
endpackage : spe_pkg

// [tb/spe_props.sv]
// link checks for the serial port facing its partner master
`timescale 1ns/1ns
module spe_props (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// resolved wires
	input wire logic sck,
	input wire logic ss_b,
	// partner drive enable
	input wire logic ctl_oe,
	// port end drives
	input wire logic dev_sck_oe,
	input wire logic dev_mosi_oe,
	input wire logic dev_miso,
	input wire logic dev_miso_oe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	logic [7:0] tgl_r; // clock toggles inside the current frame
	logic [3:0] since_r; // cycles since the clock last moved

	// count clock toggles while selected
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tgl_r <= 8'h0;
		end else if (ss_b) begin
			tgl_r <= 8'h0;
		end else if ($changed(sck)) begin
			tgl_r <= tgl_r + 8'h1;
		end
	end

	// age of the last clock edge, saturating
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			since_r <= 4'hf;
		end else if ($changed(sck)) begin
			since_r <= 4'h0;
		end else if (since_r != 4'hf) begin
			since_r <= since_r + 4'h1;
		end
	end

	miso_release_a: assert property (ss_b [*5] |-> !dev_miso_oe)
		else $error("data out still driven while deselected");
	miso_ready_a: assert property ($rose(sck) && !ss_b && ctl_oe
		&& !dev_sck_oe |-> dev_miso_oe)
		else $error("data out not driven at first clock edge");
	master_pins_a: assert property (dev_sck_oe == dev_mosi_oe)
		else $error("clock and data drive enables disagree");
	role_excl_a: assert property (!(dev_sck_oe && dev_miso_oe))
		else $error("port drives as master and slave at once");
	mode_fault_a: assert property ($fell(ss_b) && dev_sck_oe
		|-> ##[2:6] !dev_sck_oe)
		else $error("master kept driving after select went low");
	frame_bits_a: assert property ($rose(ss_b) && ctl_oe
		|-> (tgl_r + {7'h0, $changed(sck)}) % 16 == 0 && tgl_r != 8'h0)
		else $error("frame did not carry whole bytes");
	sck_quiet_a: assert property (ss_b && $past(ss_b) && !dev_sck_oe
		&& !$past(dev_sck_oe) |-> $stable(sck))
		else $error("clock moved outside a frame");
	miso_steady_a: assert property (dev_miso_oe && $past(dev_miso_oe)
		&& $past(dev_miso_oe, 2) && $changed(dev_miso) |-> since_r <= 4'h5)
		else $error("data out moved away from a clock edge");

	// main scenarios reached
	cover property ($rose(ss_b) && ctl_oe);
	cover property ($fell(dev_sck_oe));
	cover property ($rose(dev_miso_oe));
endmodule : spe_props

// [tb/spi_phase_and_error_logic_bench.sv]
// self-checking bench: port and partner master joined over the link
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
	n_fail++; $display("BAD %s exp %h got %h", n, e, g); end end
module spi_phase_and_error_logic_bench import spe_pkg::*;;
	localparam logic [7:0] EN = 8'(1 << SPE_B_EN); // port enable
	localparam logic [7:0] SELECT_PIN_DISABLE = 8'(1 << SPE_B_SELECT_PIN_DISABLE); // select off
	localparam logic [7:0] CONTROLLER_ROLE_BIT = 8'(1 << SPE_B_CONTROLLER_ROLE_BIT); // master role
	localparam logic [7:0] CLOCK_PHASE_BIT = 8'(1 << SPE_B_CLOCK_PHASE_BIT); // phase one
	localparam logic [7:0] TRANSFER_DONE_FLAG = 8'(1 << SPE_B_TRANSFER_DONE_FLAG); // done flag
	localparam logic [7:0] WRITE_CLASH_FLAG = 8'(1 << SPE_B_WRITE_CLASH_FLAG); // clash flag
	localparam logic [7:0] EARLY_DESELECT_FLAG = 8'(1 << SPE_B_EARLY_DESELECT_FLAG); // deselect
	localparam logic [7:0] ROLE_CONFLICT_FLAG = 8'(1 << SPE_B_ROLE_CONFLICT_FLAG); // role fault
	logic mclk = 1'b0; // system clock
	logic rst_b = 1'b0; // async reset
	logic [1:0] ad = 2'h0; // shared register index
	logic [7:0] wd = 8'h0; // shared write data
	logic dwr = 1'b0, drd = 1'b0, cwr = 1'b0, crd = 1'b0; // strobes
	logic ce = 1'b1; // clock enable of both ends
	logic [7:0] dq, cq, v, a, b; // read data and scratch
	logic irq_tx, irq_err; // requests
	logic [7:0] rx_q[$]; // bytes the port should have kept
	int n_fail = 0, tests_run = 0, cyc = 0; // counters

	spe_link_if link_i ();
	spe_dev spe_dev_i (.mclk(mclk), .rst_b(rst_b), .ce(ce), .addr(ad),
		.wdata(wd), .wr(dwr), .rd(drd), .rdata(dq), .irq_tx(irq_tx),
		.irq_err(irq_err), .link(link_i.dev));
	spe_ctl spe_ctl_i (.mclk(mclk), .rst_b(rst_b), .ce(ce), .addr(ad),
		.wdata(wd), .wr(cwr), .rd(crd), .rdata(cq), .link(link_i.ctl));
	spe_props spe_props_i (.mclk(mclk), .rst_b(rst_b), .sck(link_i.sck),
		.ss_b(link_i.ss_b), .ctl_oe(link_i.ctl_oe),
		.dev_sck_oe(link_i.dev_sck_oe), .dev_mosi_oe(link_i.dev_mosi_oe),
		.dev_miso(link_i.dev_miso), .dev_miso_oe(link_i.dev_miso_oe));

	// clock
	always #2 mclk = ~mclk;

	// one register cycle on either end, read data taken a cycle later
	task bus(input bit c, input bit w, input logic [1:0] adr,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge mclk);
		ad <= adr;
		wd <= d;
		{cwr, crd, dwr, drd} <= c ? {w, !w, 2'b0} : {2'b0, w, !w};
		@(posedge mclk);
		{cwr, crd, dwr, drd} <= 4'h0;
		#1 q = c ? cq : dq;
	endtask : bus

	// register write
	task wr(input bit c, input logic [1:0] adr, input logic [7:0] d);
		bus(c, 1'b1, adr, d, v);
	endtask : wr

	// register read and compare
	task rchk(input bit c, input logic [1:0] adr, input logic [7:0] e,
		input string n);
		bus(c, 1'b0, adr, 8'h0, v);
		`CHK(n, e, v)
	endtask : rchk

	// poll the partner until its byte is done, then let sync settle
	task wait_done;
		int k;
		bit seen;
		seen = 1'b0;
		// wait for done and for the partner back in idle, so a
		// following byte request is not dropped during its gap
		for (k = 0; k < 400; k++) begin
			bus(1'b1, 1'b0, SPE_C_STAT, 8'h0, v);
			seen = seen | (v[1] === 1'b1);
			if (seen && v[0] === 1'b0) break;
		end
		if (k == 400) n_fail++;
		repeat (6) @(posedge mclk);
	endtask : wait_done

	// verdict
	task tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	// hang guard
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_fail++;
			tally_and_finish;
		end
	end

	initial begin
		v = 8'($urandom(32'h3dbc));
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		rchk(0, SPE_A_CTRL, SPE_CTRL_RST, "ctrl reset");
		rchk(0, SPE_A_STAT, 8'h0, "stat reset");
		rchk(0, 2'h3, 8'h0, "unmapped");
		// one byte each way in both phases, clashing write mid-byte
		for (int p = 0; p < 2; p++) begin
			a = 8'($urandom);
			b = 8'($urandom);
			wr(0, SPE_A_CTRL, EN | 8'(p << SPE_B_CLOCK_PHASE_BIT));
			wr(0, SPE_A_DATA, a);
			wr(1, SPE_C_CFG, 8'(8 | p));
			wr(1, SPE_C_TX, b);
			rx_q.push_back(b);
			repeat (60) @(posedge mclk);
			wr(0, SPE_A_DATA, ~a);
			`CHK("irq tx busy", 1'b0, irq_tx)
			wait_done;
			rchk(1, SPE_C_RX, a, "partner rx");
			rchk(0, SPE_A_STAT, TRANSFER_DONE_FLAG | WRITE_CLASH_FLAG, "stat done");
			`CHK("irq tx done", 1'b1, irq_tx)
			rchk(0, SPE_A_DATA, rx_q.pop_front(), "port rx");
			rchk(0, SPE_A_STAT, 8'h0, "stat cleared");
			`CHK("irq tx clear", 1'b0, irq_tx)
		end
		// two bytes under one held select, never cleared between
		wr(1, SPE_C_CFG, 8'h0d);
		for (int i = 0; i < 2; i++) begin
			rx_q.push_back(8'($urandom));
			wr(1, SPE_C_TX, rx_q[i]);
			wait_done;
		end
		rchk(0, SPE_A_STAT, TRANSFER_DONE_FLAG, "stat overrun");
		`CHK("irq err overrun", 1'b0, irq_err)
		rchk(0, SPE_A_DATA, rx_q[0], "first kept");
		rx_q.delete();
		// select lifted in mid-byte, then port disabled
		wr(1, SPE_C_CFG, 8'h00);
		wr(0, SPE_A_CTRL, EN);
		wr(1, SPE_C_CFG, 8'h08);
		wr(1, SPE_C_TX, 8'($urandom));
		repeat (60) @(posedge mclk);
		wr(1, SPE_C_CFG, 8'h00);
		repeat (6) @(posedge mclk);
		rchk(0, SPE_A_STAT, EARLY_DESELECT_FLAG, "stat deselect");
		`CHK("irq deselect", 2'b00, {irq_tx, irq_err})
		wr(0, SPE_A_CTRL, 8'h00);
		rchk(0, SPE_A_STAT, 8'h00, "stat disabled");
		// select pulled low under a master port
		wr(0, SPE_A_CTRL, EN | CONTROLLER_ROLE_BIT | CLOCK_PHASE_BIT);
		wr(1, SPE_C_CFG, 8'h08);
		wr(1, SPE_C_TX, 8'h00);
		for (int k = 0; k < 20 && irq_err !== 1'b1; k++) @(posedge mclk);
		wr(1, SPE_C_CFG, 8'h00);
		`CHK("irq fault", 1'b1, irq_err)
		rchk(0, SPE_A_CTRL, CLOCK_PHASE_BIT, "ctrl fault");
		wr(0, SPE_A_CTRL, SELECT_PIN_DISABLE | CLOCK_PHASE_BIT);
		`CHK("irq masked", 1'b0, irq_err)
		wr(0, SPE_A_CTRL, CLOCK_PHASE_BIT);
		`CHK("irq kept", 1'b1, irq_err)
		rchk(0, SPE_A_STAT, ROLE_CONFLICT_FLAG, "stat fault");
		wr(0, SPE_A_CTRL, CLOCK_PHASE_BIT);
		rchk(0, SPE_A_STAT, 8'h00, "stat fault clr");
		`CHK("irq fault clr", 1'b0, irq_err)
		// a write while the clock enable is low must not land
		@(posedge mclk) ce <= 1'b0;
		wr(0, SPE_A_CTRL, EN | CLOCK_PHASE_BIT);
		@(posedge mclk) ce <= 1'b1;
		rchk(0, SPE_A_CTRL, CLOCK_PHASE_BIT, "ctrl frozen");
		wr(0, SPE_A_CTRL, EN | CLOCK_PHASE_BIT);
		rchk(0, SPE_A_CTRL, EN | CLOCK_PHASE_BIT, "ctrl enabled");
		tally_and_finish;
	end
endmodule : spi_phase_and_error_logic_bench
